// File: common/eutr_pkg.sv
package eutr_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MEM_CYCLE_NS = 750;
	localparam int SLOTS_PER_CYCLE = 15;
	localparam int CYCLE_CLKS = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOT_CLKS = CYCLE_CLKS / SLOTS_PER_CYCLE;
	localparam logic [3:0] SLOT_FIRST = 4'h1;
	localparam logic [3:0] SLOT_PRE_T3 = 4'h2;
	localparam logic [3:0] SLOT_PRE_T5 = 4'h4;
	localparam logic [3:0] SLOT_T13 = 4'hd;
	localparam logic [3:0] SLOT_LAST = 4'hf;
	// First word, bit 0 being the MSB: indirect flag bit 5, map bit 6, unit bits 10..15
	localparam int INDIRECT_BIT = 10;
	localparam int MAP_BIT = 9;
	localparam int UNIT_W = 6;
	// Indirect-format word
	localparam int CHAIN_IND_BIT = 15;
	localparam int CHAIN_IDX_BIT = 14;
	localparam int ADDR_LOW_W = 14;
	localparam int PC_W = 15;
	localparam logic [14:0] PC_RST = 15'h0000;
	localparam logic [14:0] PC_STEP = 15'h0002;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_INSTR = 8'h04;
	localparam logic [7:0] REG_OPER = 8'h08;
	localparam logic [7:0] REG_PC = 8'h0c;
	localparam logic [7:0] REG_INDEX = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_MEM_BASE = 8'h40;
	localparam int CTRL_GO = 0;
	localparam int CTRL_MCLR = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_SKIP = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {S_IDLE, S_ARM, S_I1, S_I2, S_IND, S_E1, S_E2, S_TAIL} eutr_state_e;
endpackage

// File: common/eutr_slot_if.sv
`timescale 1ns/100ps
`default_nettype none
interface eutr_slot_if;
	logic [3:0] slot;
	logic slot_last;
	logic cyc_end;
	modport src(output slot, slot_last, cyc_end);
	modport sink(input slot, slot_last, cyc_end);
endinterface
`default_nettype wire

// File: core/eutr_host.sv
`timescale 1ns/100ps
`default_nettype none
module eutr_host import eutr_pkg::*; #(
	parameter int MEM_WORDS = 16
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic test_instr_n_out,
	output logic [5:0] unit_out,
	output logic instr_sync_out,
	output logic data_here_out,
	output logic [15:0] io_bus_out,
	output logic master_clear_out,
	input wire logic sync_return_in,
	input wire logic test_return_in,
	input wire logic data_accepted_in
);
	localparam int MA_W = $clog2(MEM_WORDS);
	generate
		if (MEM_WORDS < 2 || MEM_WORDS > 16 || (1 << MA_W) != MEM_WORDS) begin : g_bad
			$error("MEM_WORDS must be a power of two from 2 to 16");
		end
	endgenerate

	eutr_slot_if slot_if();
	eutr_slot_timer u_timer (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.slot_if(slot_if)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register slave
	logic aw_full, w_full, bvalid, rvalid, w_go_ok;
	logic [7:0] aw_addr;
	logic [31:0] w_data, rdata;
	logic [1:0] bresp, rresp;
	logic [15:0] instr, oper, index;
	logic next_aw_full, next_w_full, next_bvalid, next_rvalid, next_w_go_ok;
	logic [7:0] next_aw_addr;
	logic [31:0] next_w_data, next_rdata;
	logic [1:0] next_bresp, next_rresp;
	logic [15:0] next_instr, next_oper, next_index;
	logic [15:0] mem [MEM_WORDS];
	logic wr_go, mem_hit_w, mem_hit_r;
	logic go_req, mclr_req, pc_wr;
	eutr_state_e st, next_st;
	logic [14:0] pc, next_pc;
	logic done, result, next_done, next_result;

	assign wr_go = aw_full && w_full && !bvalid;
	assign mem_hit_w = aw_addr >= REG_MEM_BASE && aw_addr < REG_MEM_BASE + 8'(4 * MEM_WORDS);
	assign mem_hit_r = s_axi_araddr_in >= REG_MEM_BASE
		&& s_axi_araddr_in < REG_MEM_BASE + 8'(4 * MEM_WORDS);
	// Strobe is kept with the data: the live wstrb is meaningless once the beat is taken
	assign go_req = wr_go && aw_addr == REG_CTRL && w_go_ok && w_data[CTRL_GO];
	assign mclr_req = wr_go && aw_addr == REG_CTRL && w_data[CTRL_MCLR];
	assign pc_wr = wr_go && aw_addr == REG_PC;

	always_comb begin
		next_aw_full = aw_full;
		next_aw_addr = aw_addr;
		next_w_full = w_full;
		next_w_data = w_data;
		next_w_go_ok = w_go_ok;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_instr = instr;
		next_oper = oper;
		next_index = index;
		if (s_axi_awvalid_in && !aw_full) begin
			next_aw_full = 1'b1;
			next_aw_addr = {s_axi_awaddr_in[7:2], 2'b00};
		end
		if (s_axi_wvalid_in && !w_full) begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata_in;
			next_w_go_ok = s_axi_wstrb_in[0];
		end
		if (bvalid && s_axi_bready_in) begin
			next_bvalid = 1'b0;
		end
		if (wr_go) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			unique case (aw_addr)
				REG_CTRL, REG_PC, REG_STATUS: ;
				REG_INSTR: next_instr = w_data[15:0];
				REG_OPER: next_oper = w_data[15:0];
				REG_INDEX: next_index = w_data[15:0];
				default: if (!mem_hit_w) next_bresp = RESP_SLVERR;
			endcase
		end
		if (rvalid && s_axi_rready_in) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			unique case ({s_axi_araddr_in[7:2], 2'b00})
				REG_CTRL: next_rdata = 32'h0;
				REG_INSTR: next_rdata = {16'h0, instr};
				REG_OPER: next_rdata = {16'h0, oper};
				REG_PC: next_rdata = {17'h0, pc};
				REG_INDEX: next_rdata = {16'h0, index};
				REG_STATUS: next_rdata = {29'h0, result, done, st != S_IDLE};
				default: begin
					next_rdata = mem_hit_r ? {16'h0, mem[s_axi_araddr_in[MA_W+1:2]]} : 32'h0;
					next_rresp = mem_hit_r ? RESP_OKAY : RESP_SLVERR;
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h0;
			w_full <= 1'b0;
			w_data <= 32'h0;
			w_go_ok <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
			instr <= 16'h0;
			oper <= 16'h0;
			index <= 16'h0;
		end else begin
			aw_full <= next_aw_full;
			aw_addr <= next_aw_addr;
			w_full <= next_w_full;
			w_data <= next_w_data;
			w_go_ok <= next_w_go_ok;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			instr <= next_instr;
			oper <= next_oper;
			index <= next_index;
		end
	end
	// Core memory image for the indirect chain; no reset, software loads it
	always_ff @(posedge clk_sys_in) begin
		if (wr_go && mem_hit_w) begin
			mem[aw_addr[MA_W+1:2]] <= w_data[15:0];
		end
	end
	assign s_axi_awready_out = !aw_full;
	assign s_axi_wready_out = !w_full;
	assign s_axi_bvalid_out = bvalid;
	assign s_axi_bresp_out = bresp;
	assign s_axi_arready_out = !rvalid;
	assign s_axi_rvalid_out = rvalid;
	assign s_axi_rdata_out = rdata;
	assign s_axi_rresp_out = rresp;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction sequencer
	logic test_n, sync, hold, dh, mclr, more, next_more;
	logic [5:0] unit;
	logic [15:0] bus;
	logic [14:0] addr;
	logic next_test_n, next_sync, next_hold, next_dh;
	logic [5:0] next_unit;
	logic [15:0] next_bus;
	logic [14:0] next_addr;
	logic t3, t5, t13e, cyc_end;
	logic [15:0] chain_word;

	assign cyc_end = slot_if.cyc_end;
	assign t3 = slot_if.slot_last && slot_if.slot == SLOT_PRE_T3;
	assign t5 = slot_if.slot_last && slot_if.slot == SLOT_PRE_T5;
	assign t13e = slot_if.slot_last && slot_if.slot == SLOT_T13;
	assign chain_word = (st == S_IND) ? mem[addr[MA_W-1:0]] : oper;

	// Effective address of an indirect-format word, with map and index applied
	function automatic logic [14:0] eff_addr(input logic [15:0] w);
		logic hi;
		hi = instr[MAP_BIT] ? pc[PC_W-1] : 1'b0;
		return 15'({hi, w[ADDR_LOW_W-1:0]} + (w[CHAIN_IDX_BIT] ? index[14:0] : 15'h0));
	endfunction

	always_comb begin
		next_st = st;
		next_pc = pc_wr ? w_data[14:0] : pc;
		next_done = done;
		next_result = result;
		next_test_n = test_n;
		next_unit = unit;
		next_sync = sync;
		next_hold = hold;
		next_dh = dh;
		next_bus = bus;
		next_addr = addr;
		next_more = more;
		unique case (st)
			S_IDLE: if (go_req) begin
				next_st = S_ARM;
				next_done = 1'b0;
			end
			S_ARM: if (cyc_end) next_st = S_I1;
			S_I1: begin
				if (t3) begin
					next_test_n = 1'b0;
					next_unit = instr[UNIT_W-1:0];
				end
				if (t5) begin
					next_sync = 1'b1;
					next_hold = 1'b1;
				end
				if (cyc_end) next_st = S_I2;
			end
			S_I2: begin
				// Skip mode only: the answer is never withheld for readiness
				if (hold && sync_return_in) next_hold = 1'b0;
				if (cyc_end && !hold) begin
					next_sync = 1'b0;
					if (instr[INDIRECT_BIT]) begin
						next_st = S_IND;
						next_addr = eff_addr(oper);
						// The flag of the address word says what the fetched word is
						next_more = oper[CHAIN_IND_BIT];
					end else begin
						next_st = S_E1;
						next_bus = oper;
						next_dh = 1'b1;
					end
				end
			end
			S_IND: if (cyc_end) begin
				if (more) begin
					next_addr = eff_addr(chain_word);
					next_more = chain_word[CHAIN_IND_BIT];
				end else begin
					next_st = S_E1;
					next_bus = chain_word;
					next_dh = 1'b1;
				end
			end
			S_E1: begin
				// Hold reused as the answered flag for this cycle
				if (dh && data_accepted_in) begin
					next_result = test_return_in;
					next_dh = 1'b0;
					next_bus = 16'h0;
					next_hold = 1'b1;
				end
				if (cyc_end && hold) begin
					next_hold = 1'b0;
					next_st = S_E2;
				end
			end
			S_E2: if (cyc_end) begin
				next_pc = pc + PC_STEP + {14'h0, result};
				next_st = S_TAIL;
			end
			S_TAIL: if (t13e) begin
				next_test_n = 1'b1;
				next_unit = 6'h0;
				next_done = 1'b1;
				next_st = S_IDLE;
			end
		endcase
		if (mclr_req) begin
			next_st = S_IDLE;
			next_test_n = 1'b1;
			next_unit = 6'h0;
			next_sync = 1'b0;
			next_hold = 1'b0;
			next_dh = 1'b0;
			next_bus = 16'h0;
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st <= S_IDLE;
			pc <= PC_RST;
			done <= 1'b0;
			result <= 1'b0;
			test_n <= 1'b1;
			unit <= 6'h0;
			sync <= 1'b0;
			hold <= 1'b0;
			dh <= 1'b0;
			bus <= 16'h0;
			addr <= 15'h0;
			more <= 1'b0;
			mclr <= 1'b0;
		end else begin
			st <= next_st;
			pc <= next_pc;
			done <= next_done;
			result <= next_result;
			test_n <= next_test_n;
			unit <= next_unit;
			sync <= next_sync;
			hold <= next_hold;
			dh <= next_dh;
			bus <= next_bus;
			addr <= next_addr;
			more <= next_more;
			mclr <= mclr_req;
		end
	end
	assign test_instr_n_out = test_n;
	assign unit_out = unit;
	assign instr_sync_out = sync;
	assign data_here_out = dh;
	assign io_bus_out = bus;
	assign master_clear_out = mclr;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	chk_enable_at_t3: assert property (st == S_I1 && t3 && !mclr_req |=> !test_instr_n_out)
		else $error("test enable not raised at T3");
	chk_sync_at_t5: assert property (st == S_I1 && t5 && !mclr_req |=> instr_sync_out && hold)
		else $error("sync and hold not set at T5");
	chk_hold_keeps_i2: assert property (st == S_I2 && hold && !sync_return_in && cyc_end
		&& !mclr_req |=> st == S_I2)
		else $error("left I cycle while held");
	chk_hold_release: assert property (st == S_I2 && hold && sync_return_in |=> !hold)
		else $error("sync return did not clear hold");
	chk_immediate_path: assert property (st == S_I2 && cyc_end && !hold && !instr[INDIRECT_BIT]
		&& !mclr_req |=> st == S_E1 && data_here_out && io_bus_out == $past(oper))
		else $error("immediate operand not presented");
	chk_bus_with_dh: assert property (!data_here_out |-> io_bus_out == 16'h0)
		else $error("bus driven without data here");
	chk_dh_drop: assert property ($fell(data_here_out) && !$past(mclr_req)
		|-> $past(data_accepted_in) && result == $past(test_return_in))
		else $error("data here dropped before sampling");
	chk_skip_pc: assert property (st == S_E2 && cyc_end && !pc_wr
		|=> pc == $past(pc) + 15'h2 + {14'h0, $past(result)})
		else $error("program counter step wrong");
	chk_enable_held: assert property (st inside {S_I2, S_IND, S_E1, S_E2} |-> !test_instr_n_out
		&& unit_out == instr[5:0])
		else $error("test enable dropped early");
	chk_release_t13: assert property (st == S_TAIL && t13e && !mclr_req
		|=> test_instr_n_out && st == S_IDLE)
		else $error("enable not released at T13");
	chk_master_clear: assert property (mclr_req |=> master_clear_out && !instr_sync_out
		&& !data_here_out && st == S_IDLE)
		else $error("master clear did not idle");
	cov_skip: cover property (st == S_E2 && result && cyc_end);
	cov_no_skip: cover property (st == S_E2 && !result && cyc_end);
	cov_chain: cover property (st == S_IND ##1 st == S_E1);
	cov_long_wait: cover property (st == S_I2 && hold && cyc_end);
endmodule
`default_nettype wire

// File: core/eutr_slot_timer.sv
`timescale 1ns/100ps
`default_nettype none
module eutr_slot_timer import eutr_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	eutr_slot_if.src slot_if
);
	logic [3:0] tick;
	logic [3:0] slot;
	logic [3:0] next_tick;
	logic [3:0] next_slot;
	logic last;

	// Free-running memory cycle of fifteen equal timing slots
	assign last = (tick == 4'(SLOT_CLKS - 1));
	always_comb begin
		next_tick = last ? 4'h0 : tick + 4'h1;
		next_slot = slot;
		if (last) begin
			next_slot = (slot == SLOT_LAST) ? SLOT_FIRST : slot + 4'h1;
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			tick <= 4'h0;
			slot <= SLOT_FIRST;
		end else begin
			tick <= next_tick;
			slot <= next_slot;
		end
	end
	assign slot_if.slot = slot;
	assign slot_if.slot_last = last;
	assign slot_if.cyc_end = last && (slot == SLOT_LAST);
endmodule
`default_nettype wire

// File: test/eutr_host_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module eutr_host_tb import eutr_pkg::*;;
	logic clk_sys_in = 1'b0, rst_in = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] wstrb = 4'h0, adly = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tin_n, isync, dhere, mclr, srt, trt, dacc;
	logic [1:0] bresp, rresp, rs, bs;
	logic [5:0] unit, cap_unit;
	logic [15:0] bus, cap_bus, cond = 16'h0;
	logic conn = 1'b1, dh_q = 1'b0, acc_q = 1'b0, tin_q = 1'b1, mc_seen = 1'b0;
	int n_fail = 0, num_checks = 0, cyc = 0, lowcnt = 0, bad15 = 0, lc0 = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	eutr_host #(.MEM_WORDS(16)) DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .test_instr_n_out(tin_n),
		.unit_out(unit), .instr_sync_out(isync), .data_here_out(dhere), .io_bus_out(bus),
		.master_clear_out(mclr), .sync_return_in(srt), .test_return_in(trt),
		.data_accepted_in(dacc));
	eutr_periph #(.UNIT_ID(6'h2a)) PERIPH (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.test_instr_n_in(tin_n), .unit_in(unit), .instr_sync_in(isync),
		.data_here_in(dhere), .io_bus_in(bus), .master_clear_in(mclr),
		.connected_in(conn), .cond_in(cond), .accept_delay_in(adly),
		.sync_return_out(srt), .test_return_out(trt), .data_accepted_out(dacc));
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk_sys_in);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk_sys_in);
		bs = bresp;
		bready <= 1'b0;
		// One idle edge keeps a following call from re-raising bready in this step
		@(posedge clk_sys_in);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys_in); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys_in); while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	task automatic run(input logic [15:0] ins, input logic [15:0] op);
		axi_wr(REG_INSTR, {16'h0, ins});
		axi_wr(REG_OPER, {16'h0, op});
		lc0 = lowcnt;
		axi_wr(REG_CTRL, 32'h1);
		do axi_rd(REG_STATUS); while (rd[STAT_DONE] !== 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Monitor samples pre-edge values, so captures match what the peripheral saw
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (tin_n === 1'b0) lowcnt <= lowcnt + 1;
		if (dhere && !dh_q) cap_bus <= bus;
		if (!tin_n && tin_q) cap_unit <= unit;
		if (mclr === 1'b1) mc_seen <= 1'b1;
		if (dh_q && !dhere && !acc_q) bad15 <= bad15 + 1;
		dh_q <= dhere;
		acc_q <= dacc;
		tin_q <= tin_n;
		if (cyc == 40000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		`CHK("instr_n idle", 1'b1, tin_n)
		`CHK("sync idle", 1'b0, isync)
		`CHK("data_here idle", 1'b0, dhere)
		axi_rd(8'h20);
		`CHK("unmapped resp", RESP_SLVERR, rs)
		axi_wr(8'h20, 32'h0);
		`CHK("unmapped write resp", RESP_SLVERR, bs)
		axi_wr(REG_PC, 32'h10);
		`CHK("pc write resp", RESP_OKAY, bs)
		cond <= 16'h0004;
		run(16'h002a, 16'h0004);
		`CHK("bus word", 16'h0004, cap_bus)
		`CHK("unit", 6'h2a, cap_unit)
		`CHK("instr clocks", CYCLE_CLKS * 3 + 26 * SLOT_CLKS, lowcnt - lc0)
		`CHK("skip set", 1'b1, rd[STAT_SKIP])
		axi_rd(REG_PC);
		`CHK("pc skip", 15'h10 + PC_STEP + 15'h1, rd[14:0])
		cond <= 16'h0001;
		adly <= 4'h8;
		run(16'h002a, 16'h0006);
		`CHK("skip clear", 1'b0, rd[STAT_SKIP])
		axi_rd(REG_PC);
		`CHK("pc next", 15'h13 + PC_STEP, rd[14:0])
		axi_wr(REG_INDEX, 32'h3);
		axi_wr(REG_MEM_BASE + 8'h08, 32'h4005);
		axi_wr(REG_MEM_BASE + 8'h20, 32'h0100);
		cond <= 16'h0100;
		adly <= 4'h0;
		run(16'h042a, 16'h8002);
		`CHK("chain word", 16'h0100, cap_bus)
		`CHK("extra cycles", 1'b1, lowcnt - lc0 > CYCLE_CLKS * 3 + 26 * SLOT_CLKS)
		`CHK("chain skip", 1'b1, rd[STAT_SKIP])
		conn <= 1'b0;
		axi_wr(REG_CTRL, 32'h1);
		repeat (4 * CYCLE_CLKS) @(posedge clk_sys_in);
		`CHK("held sync", 1'b1, isync)
		`CHK("no data_here", 1'b0, dhere)
		axi_wr(REG_CTRL, 32'h2);
		repeat (2) @(posedge clk_sys_in);
		`CHK("clear pulse", 1'b1, mc_seen)
		`CHK("released", 1'b1, tin_n)
		axi_rd(REG_STATUS);
		`CHK("busy after clear", 1'b0, rd[STAT_BUSY])
		`CHK("early drop", 0, bad15)
		complete_run();
	end
endmodule
`default_nettype wire

// File: test/eutr_periph.sv
`timescale 1ns/100ps
`default_nettype none
module eutr_periph #(
	parameter logic [5:0] UNIT_ID = 6'h2a
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic test_instr_n_in,
	input wire logic [5:0] unit_in,
	input wire logic instr_sync_in,
	input wire logic data_here_in,
	input wire logic [15:0] io_bus_in,
	input wire logic master_clear_in,
	input wire logic connected_in,
	input wire logic [15:0] cond_in,
	input wire logic [3:0] accept_delay_in,
	output logic sync_return_out,
	output logic test_return_out,
	output logic data_accepted_out
);
	logic chosen;
	logic test_ready;
	logic sync_flop;
	logic acc_flop;
	logic [3:0] acc_cnt;
	// A disconnected unit never answers, which leaves the host parked in its I cycle
	assign chosen = !test_instr_n_in && unit_in == UNIT_ID && connected_in;
	assign test_ready = chosen && data_here_in;
	assign test_return_out = test_ready && |(io_bus_in & cond_in);
	assign sync_return_out = sync_flop;
	assign data_accepted_out = acc_flop;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sync_flop <= 1'b0;
			acc_flop <= 1'b0;
			acc_cnt <= 4'h0;
		end else if (master_clear_in) begin
			sync_flop <= 1'b0;
			acc_flop <= 1'b0;
			acc_cnt <= 4'h0;
		end else begin
			if (!instr_sync_in) begin
				sync_flop <= 1'b0;
			end else if (chosen && !sync_flop) begin
				sync_flop <= 1'b1;
			end
			if (!data_here_in) begin
				acc_flop <= 1'b0;
				acc_cnt <= 4'h0;
			end else if (test_ready && !acc_flop) begin
				if (acc_cnt == accept_delay_in) begin
					acc_flop <= 1'b1;
				end else begin
					acc_cnt <= acc_cnt + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire
